// file: fsu_cfg.svh
`ifndef FSU_CFG_SVH
`define FSU_CFG_SVH
// Operation
// - Take transmit word only when ready and valid
// - Valid dropped mid-frame sends idles instead
// - Valid low outside an open frame: bus ignored
// - Keep counts closing bytes, read only with last
// - Frame wrapped by start and end pairs
// - Idle code groups when no data available
// - Byte pairs; odd frames get a pad
// - Most significant byte travels first
// - Frame data striped across all lanes
// - Receive strips idles, compensation and delimiters
// - Receive assembles words and marks frame end
// - User port follows stream valid/ready conventions
// - Optional streaming form without delimiters
// - Receive has no backpressure, no elastic buffer
// - Start in top lane, end in bottom lane
// - Ready drops one cycle after last word (framed form only)
// - Ready withheld from the cycle after a compensation request

// Lane geometry
`define FSU_LANE_BYTES       2
`define FSU_LANES_DEF        2
`define FSU_BUF_DEPTH        2
// Control characters, all sent with the control flag set
`define FSU_CHAR_IDLE        8'hbc
`define FSU_CHAR_START_HI    8'h5c
`define FSU_CHAR_START_LO    8'hfb
`define FSU_CHAR_END_HI      8'hfd
`define FSU_CHAR_END_LO      8'hfe
`define FSU_CHAR_PAD         8'h9c
`define FSU_CHAR_COMP        8'hf7
`endif

// file: fsu_pkg.sv
package fsu_pkg;
    typedef logic [7:0] fsu_byte_t;

    // Transmit framing states
    typedef enum logic [2:0]
    {
        FSU_TX_IDLE  = 3'b001,
        FSU_TX_FRAME = 3'b010,
        FSU_TX_END   = 3'b100
    } fsu_tx_state_e;
endpackage : fsu_pkg

// file: fsu_pair_buffer.sv
`timescale 1ns/1ns
`include "fsu_cfg.svh"
// Two-entry buffer; head register drives the output directly
module fsu_pair_buffer
    import fsu_pkg::*;
#(
    parameter int WIDTH = 40,
    parameter int DEPTH = `FSU_BUF_DEPTH
)
(
    input  wire logic             mclk_in,
    input  wire logic             rst_b_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out,
    output logic [1:0]            level_out
);
    if (DEPTH != 2)
    begin : g_chk
        $error("fsu_pair_buffer supports exactly two entries");
    end

    logic [WIDTH-1:0] spare;
    logic             spare_valid;
    logic             pop;
    logic             push;

    assign pop          = out_valid_out && out_ready_in;
    assign push         = in_valid_in && in_ready_out;
    // Ready from a flop only, so the upstream path stays short
    assign in_ready_out = !spare_valid;
    assign level_out    = {1'b0, out_valid_out} + {1'b0, spare_valid};

    // Head and spare move together; spare refills the head first to keep order
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            out_valid_out <= 1'b0;
            out_data_out  <= '0;
            spare         <= '0;
            spare_valid   <= 1'b0;
        end
        else if (!out_valid_out || pop)
        begin
            if (spare_valid)
            begin
                out_data_out  <= spare;
                out_valid_out <= 1'b1;
                spare_valid   <= push;
                spare         <= in_data_in;
            end
            else
            begin
                out_data_out  <= in_data_in;
                out_valid_out <= push;
            end
        end
        else if (push)
        begin
            spare       <= in_data_in;
            spare_valid <= 1'b1;
        end
    end
endmodule : fsu_pair_buffer

// file: fsu_framer.sv
`timescale 1ns/1ns
`include "fsu_cfg.svh"
// Framing user port: stream in, lane words out, and the reverse
module fsu_framer
    import fsu_pkg::*;
#(
    parameter int LANES     = `FSU_LANES_DEF,
    parameter bit STREAMING = 1'b0
)
(
    input  wire logic                                mclk_in,
    input  wire logic                                rst_b_in,
    input  wire logic                                tx_valid_in,
    output logic                                     tx_ready_out,
    input  wire logic [8*LANES*`FSU_LANE_BYTES-1:0]  tx_data_in,
    input  wire logic                                tx_last_in,
    input  wire logic [LANES*`FSU_LANE_BYTES-1:0]    tx_keep_in,
    input  wire logic                                comp_insert_request_in,
    output logic                                     tx_lane_valid_out,
    input  wire logic                                tx_lane_ready_in,
    output logic [8*LANES*`FSU_LANE_BYTES-1:0]       tx_lane_data_out,
    output logic [LANES*`FSU_LANE_BYTES-1:0]         tx_lane_ctrl_out,
    input  wire logic                                rx_lane_valid_in,
    input  wire logic [8*LANES*`FSU_LANE_BYTES-1:0]  rx_lane_data_in,
    input  wire logic [LANES*`FSU_LANE_BYTES-1:0]    rx_lane_ctrl_in,
    output logic                                     rx_valid_out,
    output logic [8*LANES*`FSU_LANE_BYTES-1:0]       rx_data_out,
    output logic                                     rx_last_out,
    output logic [LANES*`FSU_LANE_BYTES-1:0]         rx_keep_out
);
    localparam int N  = LANES * `FSU_LANE_BYTES;
    localparam int CW = $clog2(N + 1);

    // End pair plus two deferred bytes must fit one word
    if (LANES < 2)
    begin : g_chk
        $error("fsu_framer needs at least two lanes");
    end

    // Number of set keep bits
    function automatic int fsu_ones(input logic [N-1:0] v);
        int n;
        n = 0;
        for (int i = 0; i < N; i++)
            n += int'(v[i]);
        return n;
    endfunction : fsu_ones

    // Keep mask with the top cnt bytes valid
    function automatic logic [N-1:0] fsu_mask(input int cnt);
        logic [N-1:0] m;
        m = '0;
        for (int i = 0; i < N; i++)
            m[N-1-i] = (i < cnt);
        return m;
    endfunction : fsu_mask

    fsu_tx_state_e    state;
    fsu_tx_state_e    next_state;
    fsu_byte_t        held [2];
    fsu_byte_t        next_held [2];
    logic [1:0]       held_cnt;
    logic [1:0]       next_held_cnt;
    logic             next_tx_ready;
    fsu_byte_t        ob [N];
    logic [N-1:0]     oc;
    logic [9*N-1:0]   push_word;
    logic [9*N-1:0]   lane_word;
    logic             run;
    logic [1:0]       level;
    logic             accept;
    int               kcnt;
    int               c;
    int               lvl_n;

    assign accept = tx_ready_out && tx_valid_in;
    assign kcnt   = tx_last_in ? fsu_ones(tx_keep_in) : N;
    assign c      = (kcnt < N - 2) ? kcnt : N - 2;

    // Transmit word builder; slot 0 is the most significant byte
    always_comb
    begin
        next_state    = state;
        next_held     = held;
        next_held_cnt = held_cnt;
        for (int i = 0; i < N; i++)
        begin
            ob[i] = `FSU_CHAR_IDLE;
            oc[i] = 1'b1;
        end
        if (comp_insert_request_in && !accept)
        begin
            for (int i = 0; i < N; i++)
                ob[i] = `FSU_CHAR_COMP;
        end
        else if (STREAMING)
        begin
            // No delimiters at all in streaming form
            if (accept)
            begin
                for (int i = 0; i < N; i++)
                begin
                    ob[i] = tx_data_in[8*N-1-8*i -: 8];
                    oc[i] = 1'b0;
                end
            end
        end
        else if (accept && state != FSU_TX_END)
        begin
            if (state == FSU_TX_IDLE)
            begin
                ob[0] = `FSU_CHAR_START_HI;
                ob[1] = `FSU_CHAR_START_LO;
            end
            else
            begin
                ob[0] = held[0];
                ob[1] = held[1];
                oc[0] = 1'b0;
                oc[1] = 1'b0;
            end
            // Last two bytes slip one frame word behind the start pair
            for (int i = 0; i < N - 2; i++)
            begin
                if (i < c)
                begin
                    ob[2+i] = tx_data_in[8*N-1-8*i -: 8];
                    oc[2+i] = 1'b0;
                end
            end
            if (c % 2 == 1)
                ob[2+c] = `FSU_CHAR_PAD;
            next_held[0]  = tx_data_in[15:8];
            next_held[1]  = tx_data_in[7:0];
            next_held_cnt = 2'(kcnt - c);
            next_state    = tx_last_in ? FSU_TX_END : FSU_TX_FRAME;
        end
        else if (state == FSU_TX_END)
        begin
            // Deferred bytes, then idles, end pair in the bottom lane
            for (int i = 0; i < 2; i++)
            begin
                if (i < int'(held_cnt))
                begin
                    ob[i] = held[i];
                    oc[i] = 1'b0;
                end
            end
            if (held_cnt == 2'h1)
                ob[1] = `FSU_CHAR_PAD;
            ob[N-2]       = `FSU_CHAR_END_HI;
            ob[N-1]       = `FSU_CHAR_END_LO;
            next_held_cnt = 2'h0;
            next_state    = FSU_TX_IDLE;
        end
        // Frame open but valid low: idles already loaded
        // No frame and valid low: bus ignored
    end

    // Flatten the slots: data bytes first, control flags below
    always_comb
    begin
        push_word = '0;
        for (int i = 0; i < N; i++)
        begin
            push_word[9*N-1-8*i -: 8] = ob[i];
            push_word[N-1-i]          = oc[i];
        end
    end

    // Buffer occupancy one cycle ahead, so ready can be a flop
    always_comb
    begin
        lvl_n = int'(level) + int'(run) - int'(tx_lane_valid_out && tx_lane_ready_in);
        // A stalled end word keeps its state, so ready must not rise before it is pushed
        next_tx_ready = (lvl_n < 2) && !comp_insert_request_in
                        && (STREAMING || (run ? next_state : state) != FSU_TX_END);
    end

    // Framing state advances only when a word can be pushed
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            state    <= FSU_TX_IDLE;
            held[0]  <= 8'h00;
            held[1]  <= 8'h00;
            held_cnt <= 2'h0;
        end
        else if (run)
        begin
            state    <= next_state;
            held     <= next_held;
            held_cnt <= next_held_cnt;
        end
    end

    // User ready
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            tx_ready_out <= 1'b0;
        else
            tx_ready_out <= next_tx_ready;
    end

    // A stalled lane fills this buffer before the user sees ready drop
    fsu_pair_buffer #(
        .WIDTH (9*N),
        .DEPTH (`FSU_BUF_DEPTH)
    ) u_lane_buf (
        .mclk_in       (mclk_in),
        .rst_b_in      (rst_b_in),
        .in_valid_in   (1'b1),
        .in_ready_out  (run),
        .in_data_in    (push_word),
        .out_valid_out (tx_lane_valid_out),
        .out_ready_in  (tx_lane_ready_in),
        .out_data_out  (lane_word),
        .level_out     (level)
    );

    assign tx_lane_data_out = lane_word[9*N-1:N];
    assign tx_lane_ctrl_out = lane_word[N-1:0];

    fsu_byte_t    stash [N];
    fsu_byte_t    next_stash [N];
    logic [CW-1:0] stash_cnt;
    logic [CW-1:0] next_stash_cnt;
    logic         in_frame;
    logic         next_in_frame;
    logic         next_rx_valid;
    logic         next_rx_last;
    logic [8*N-1:0] next_rx_data;
    logic [N-1:0] next_rx_keep;
    fsu_byte_t    cb [2*N];
    logic         sof;
    logic         eof;
    logic         stop;
    int           s;
    int           d;
    int           t;

    // Receive: drop control bytes, left-align data through the stash
    always_comb
    begin
        next_stash     = stash;
        next_stash_cnt = stash_cnt;
        next_in_frame  = in_frame;
        next_rx_valid  = 1'b0;
        next_rx_last   = 1'b0;
        next_rx_data   = rx_data_out;
        next_rx_keep   = rx_keep_out;
        stop           = 1'b0;
        d              = 0;
        t              = 0;
        sof = rx_lane_ctrl_in[N-1] && rx_lane_ctrl_in[N-2]
              && rx_lane_data_in[8*N-1 -: 8] == `FSU_CHAR_START_HI
              && rx_lane_data_in[8*N-9 -: 8] == `FSU_CHAR_START_LO;
        eof = rx_lane_ctrl_in[1] && rx_lane_ctrl_in[0]
              && rx_lane_data_in[15:8] == `FSU_CHAR_END_HI
              && rx_lane_data_in[7:0] == `FSU_CHAR_END_LO;
        s = sof ? 0 : int'(stash_cnt);
        for (int i = 0; i < 2*N; i++)
            cb[i] = (i < N) ? stash[i] : 8'h00;
        if (rx_lane_valid_in && STREAMING)
        begin
            // Whole data words pass straight through
            next_rx_valid = (rx_lane_ctrl_in == '0);
            next_rx_data  = rx_lane_data_in;
            next_rx_keep  = '1;
        end
        else if (rx_lane_valid_in && (sof || in_frame))
        begin
            for (int i = 0; i < N; i++)
            begin
                if (!(sof && i < 2) && !stop && !rx_lane_ctrl_in[N-1-i])
                begin
                    cb[s+d] = rx_lane_data_in[8*N-1-8*i -: 8];
                    d++;
                end
                else if (!(sof && i < 2))
                    stop = 1'b1;
            end
            t = s + d;
            for (int i = 0; i < N; i++)
                next_stash[i] = (t >= N) ? cb[N+i] : cb[i];
            next_stash_cnt = (t >= N) ? CW'(t - N) : CW'(t);
            if (t >= N || (eof && t > 0))
            begin
                next_rx_valid = 1'b1;
                next_rx_last  = eof && t <= N;
                next_rx_keep  = (t >= N) ? '1 : fsu_mask(t);
                for (int i = 0; i < N; i++)
                    next_rx_data[8*N-1-8*i -: 8] = cb[i];
            end
            if (eof)
            begin
                next_stash_cnt = '0;
                next_in_frame  = 1'b0;
            end
            else
                next_in_frame = 1'b1;
        end
    end

    // Receive outputs; no ready input, words are offered once
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            rx_valid_out <= 1'b0;
            rx_last_out  <= 1'b0;
            rx_data_out  <= '0;
            rx_keep_out  <= '0;
            in_frame     <= 1'b0;
            stash_cnt    <= '0;
            for (int i = 0; i < N; i++)
                stash[i] <= 8'h00;
        end
        else
        begin
            rx_valid_out <= next_rx_valid;
            rx_last_out  <= next_rx_last;
            rx_data_out  <= next_rx_data;
            rx_keep_out  <= next_rx_keep;
            in_frame     <= next_in_frame;
            stash_cnt    <= next_stash_cnt;
            stash        <= next_stash;
        end
    end
endmodule : fsu_framer

// file: fsu_framer_asserts.sv
`timescale 1ns/1ns
`include "fsu_cfg.svh"
module fsu_framer_asserts
    import fsu_pkg::*;
#(
    parameter int LANES     = `FSU_LANES_DEF,
    parameter bit STREAMING = 1'b0
)
(
    input wire logic                               mclk_in,
    input wire logic                               rst_b_in,
    input wire logic                               tx_valid_in,
    input wire logic                               tx_ready_out,
    input wire logic [8*LANES*`FSU_LANE_BYTES-1:0] tx_data_in,
    input wire logic                               tx_last_in,
    input wire logic [LANES*`FSU_LANE_BYTES-1:0]   tx_keep_in,
    input wire logic                               comp_insert_request_in,
    input wire logic                               tx_lane_valid_out,
    input wire logic                               tx_lane_ready_in,
    input wire logic [8*LANES*`FSU_LANE_BYTES-1:0] tx_lane_data_out,
    input wire logic [LANES*`FSU_LANE_BYTES-1:0]   tx_lane_ctrl_out,
    input wire logic                               rx_lane_valid_in,
    input wire logic [8*LANES*`FSU_LANE_BYTES-1:0] rx_lane_data_in,
    input wire logic [LANES*`FSU_LANE_BYTES-1:0]   rx_lane_ctrl_in,
    input wire logic                               rx_valid_out,
    input wire logic [8*LANES*`FSU_LANE_BYTES-1:0] rx_data_out,
    input wire logic                               rx_last_out,
    input wire logic [LANES*`FSU_LANE_BYTES-1:0]   rx_keep_out
);
    localparam int NB = LANES * `FSU_LANE_BYTES;

    // Single domain, so one clock and one disable for all
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);

    chk_end_gap_ready: assert property (tx_valid_in && tx_ready_out && tx_last_in |=> !tx_ready_out)
        else $error("ready not dropped after last word");
    chk_comp_holds_ready: assert property (comp_insert_request_in |=> !tx_ready_out)
        else $error("ready high during compensation");
    chk_lane_word_held: assert property (tx_lane_valid_out && !tx_lane_ready_in |=>
        tx_lane_valid_out && $stable(tx_lane_data_out) && $stable(tx_lane_ctrl_out))
        else $error("lane word changed while stalled");
    chk_start_top_lane: assert property (tx_lane_valid_out && (&tx_lane_ctrl_out[1:0]) |->
        tx_lane_data_out[15:0] != {`FSU_CHAR_START_HI, `FSU_CHAR_START_LO})
        else $error("start pair outside top slots");
    chk_end_low_lane: assert property (tx_lane_valid_out && (&tx_lane_ctrl_out[NB-1 -: 2]) |->
        tx_lane_data_out[8*NB-1 -: 16] != {`FSU_CHAR_END_HI, `FSU_CHAR_END_LO})
        else $error("end pair outside bottom slots");
    chk_last_with_valid: assert property (rx_last_out |-> rx_valid_out)
        else $error("receive last without valid");
    chk_keep_full_mid: assert property (rx_valid_out && !rx_last_out |-> &rx_keep_out)
        else $error("partial keep before frame end");
    chk_keep_nonempty: assert property (rx_valid_out && rx_last_out |-> rx_keep_out[NB-1])
        else $error("empty final word delivered");
    chk_rx_follows_lane: assert property (rx_valid_out |-> $past(rx_lane_valid_in))
        else $error("receive word without lane word");
endmodule : fsu_framer_asserts

bind fsu_framer fsu_framer_asserts #(.LANES(LANES), .STREAMING(STREAMING)) i_fsu_framer_asserts (
    .mclk_in, .rst_b_in, .tx_valid_in, .tx_ready_out, .tx_data_in, .tx_last_in, .tx_keep_in,
    .comp_insert_request_in, .tx_lane_valid_out, .tx_lane_ready_in, .tx_lane_data_out,
    .tx_lane_ctrl_out, .rx_lane_valid_in, .rx_lane_data_in, .rx_lane_ctrl_in, .rx_valid_out,
    .rx_data_out, .rx_last_out, .rx_keep_out);

// file: fsu_lane_partner.sv
`timescale 1ns/1ns
// Lane loopback: takes transmit lane words and replays them as received words
module fsu_lane_partner
(
    input  wire logic        mclk_in,
    input  wire logic        rst_b_in,
    input  wire logic        stall_in,
    input  wire logic        lane_valid_in,
    input  wire logic [31:0] lane_data_in,
    input  wire logic [3:0]  lane_ctrl_in,
    output logic             lane_ready_out,
    output logic             rx_valid_out,
    output logic [31:0]      rx_data_out,
    output logic [3:0]       rx_ctrl_out
);
    assign lane_ready_out = !stall_in;

    // Pushes every taken word with no way to hold it back; idle data toggles
    always_ff @(posedge mclk_in or negedge rst_b_in)
        if (!rst_b_in)
        begin
            rx_valid_out <= 1'b0;
            rx_data_out  <= 32'h0;
            rx_ctrl_out  <= 4'h0;
        end
        else if (lane_valid_in && !stall_in)
        begin
            rx_valid_out <= 1'b1;
            rx_data_out  <= lane_data_in;
            rx_ctrl_out  <= lane_ctrl_in;
        end
        else
        begin
            rx_valid_out <= 1'b0;
            rx_data_out  <= ~rx_data_out; // Stale data must not look valid
            rx_ctrl_out  <= ~rx_ctrl_out;
        end
endmodule : fsu_lane_partner

// file: fsu_framer_bench.sv
`timescale 1ns/1ns
module fsu_framer_bench;
    typedef struct packed {logic [31:0] d; logic l; logic [3:0] k;} fsu_exp_s;
    logic        mclk_in = 1'b0;
    logic        rst_b_in = 1'b0;
    logic        tx_valid = 1'b0;
    logic        tx_last = 1'b0;
    logic [31:0] tx_data = 32'h0;
    logic [3:0]  tx_keep = 4'h0;
    logic        comp = 1'b0;
    logic        stall = 1'b0;
    logic        tx_ready, lane_valid, lane_ready, rxl_valid, rx_valid, rx_last;
    logic [31:0] lane_data, rxl_data, rx_data, m;
    logic [3:0]  lane_ctrl, rxl_ctrl, rx_keep, km;
    logic [31:0] state = 32'hfaba;
    logic [31:0] r;
    fsu_exp_s    exp_q[$];
    fsu_exp_s    e;
    int          fail_count = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    int          f, w, nw, kc;

    fsu_framer #(.LANES(2), .STREAMING(1'b0)) i_fsu_framer (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
        .tx_valid_in(tx_valid), .tx_ready_out(tx_ready), .tx_data_in(tx_data), .tx_last_in(tx_last),
        .tx_keep_in(tx_keep), .comp_insert_request_in(comp), .tx_lane_valid_out(lane_valid),
        .tx_lane_ready_in(lane_ready), .tx_lane_data_out(lane_data), .tx_lane_ctrl_out(lane_ctrl),
        .rx_lane_valid_in(rxl_valid), .rx_lane_data_in(rxl_data), .rx_lane_ctrl_in(rxl_ctrl),
        .rx_valid_out(rx_valid), .rx_data_out(rx_data), .rx_last_out(rx_last), .rx_keep_out(rx_keep));
    fsu_lane_partner i_fsu_lane_partner (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .stall_in(stall),
        .lane_valid_in(lane_valid), .lane_data_in(lane_data), .lane_ctrl_in(lane_ctrl),
        .lane_ready_out(lane_ready), .rx_valid_out(rxl_valid), .rx_data_out(rxl_data),
        .rx_ctrl_out(rxl_ctrl));

    function automatic logic [31:0] xs();
        state = state ^ (state << 13);
        state = state ^ (state >> 17);
        state = state ^ (state << 5);
        return state;
    endfunction : xs

    task automatic check(input logic [36:0] seen, input logic [36:0] want);
        cmp_count++;
        if (seen !== want)
        begin
            fail_count++;
            $display("mismatch t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check

    task automatic final_report();
        if (fail_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : final_report

    initial
    begin
        forever #5 mclk_in = ~mclk_in;
    end

    // Long stall bursts fill the lane buffer; comp bursts last six cycles
    always @(posedge mclk_in)
    begin
        cyc++;
        stall <= ((cyc % 200) < 20) || (xs() % 4 == 0);
        comp  <= (cyc % 150) >= 144;
        if (cyc == 20000)
        begin
            fail_count++;
            final_report();
        end
    end

    // Compares each received word with the oldest note, masked to valid bytes
    always @(posedge mclk_in)
    begin
        if (rst_b_in && rx_valid === 1'b1)
        begin
            e = 'x;
            if (exp_q.size() > 0)
                e = exp_q.pop_front();
            for (int i = 0; i < 4; i++)
                m[8*i +: 8] = {8{e.k[i]}};
            check({rx_data & m, rx_last, rx_keep}, {e.d & m, e.l, e.k});
        end
    end

    // Random frames of 1..3 words, random closing length, random pauses
    initial
    begin
        repeat (5) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        for (f = 0; f < 80; f++)
        begin
            nw = 1 + int'(xs() % 3);
            kc = 1 + int'(xs() % 4);
            for (w = 0; w < nw; w++)
            begin
                r = xs();
                km = (w == nw - 1) ? 4'hf << (4 - kc) : 4'hf;
                tx_valid <= 1'b1;
                tx_last  <= (w == nw - 1);
                tx_data  <= r;
                tx_keep  <= (w == nw - 1) ? 4'(4'hf >> (4 - kc)) : 4'(xs());
                exp_q.push_back('{d: r, l: (w == nw - 1), k: km});
                do @(posedge mclk_in); while (tx_ready !== 1'b1);
                if (xs() % 4 == 0)
                begin
                    tx_valid <= 1'b0;
                    tx_data  <= xs();
                    repeat (1 + int'(xs() % 3)) @(posedge mclk_in);
                end
            end
        end
        tx_valid <= 1'b0;
        repeat (300) @(posedge mclk_in);
        check(37'(exp_q.size()), 37'h0);
        final_report();
    end
endmodule : fsu_framer_bench
